// File: verilog/idpage_params.svh
// Offsets, field positions, reset values and page constants of the identify page block.
//------------------------------------------------------------------------------
// Operation
//------------------------------------------------------------------------------
// Operation
// - Identify command returns the page by PIO data-in, like one sector read.
// - Word 0 bit 6 reads one: drive is non-removable.
// - Word 2 holds C837h: no spin-up subcommand, identify data complete.
// - Model number left aligned, serial right aligned, both space padded.
// - Word 47 gives the largest sector count per interrupt for multiple commands.
// - Capabilities word bit 13 reads zero: standby timer is vendor defined.
// - Capabilities bit 11 reports IORDY supported, bit 10 IORDY may be disabled.
// - Capabilities bit 9 reports LBA support, bit 8 DMA command support.
// - Word 51 upper byte holds 02h, the highest original PIO mode.
// - Word 53 bits 0, 1, 2 flag words 54-58, 64-70 and 88 valid.
// - Word 59: bits 15-9 zero, bit 8 one, low byte 00h or 01h.
// - Words 60-61 give LBA28 sector count, words 100-103 the 48-bit count.
// - Word 63 defaults to 0007h; the host may change its selection byte.
// - Word 64 reports advanced PIO modes 3 and 4 as supported.
// - Words 65 to 68 each return cycle time 0078h.
// - Word 75 returns queue depth minus one, default 001fh.
// - Word 76 defaults to 0306h serial capabilities.
// - Word 78 reports supported serial features; word 79 the host-changeable enabled subset.
// - Words 85 to 87 report enabled features, default 7429h, 3401h, 4020h.
// - Word 88 reports UDMA 0-6 supported, mode 6 selected; selection follows host.
// - Word 89 gives security erase time, default 0003h.
// - Word 128 reflects security state, default 0021h, written by software through the security register.
// - Word 209 reports block alignment, default 4000h.
// - Word 217 returns 0001h, the non-rotating medium code.
`ifndef IDPAGE_PARAMS_SVH
`define IDPAGE_PARAMS_SVH

// APB register offsets.
`define IDP_REG_CTRL     8'h00
`define IDP_REG_LBA28    8'h04
`define IDP_REG_LBA48_LO 8'h08
`define IDP_REG_LBA48_HI 8'h0c
`define IDP_REG_MODE     8'h10
`define IDP_REG_SATA_EN  8'h14
`define IDP_REG_FEAT85   8'h18
`define IDP_REG_FEAT86   8'h1c
`define IDP_REG_FEAT87   8'h20
`define IDP_REG_SECURITY 8'h24
`define IDP_REG_STRLEN   8'h28
`define IDP_SERIAL_BASE  8'h40
`define IDP_MODEL_BASE   8'h60
`define IDP_FW_BASE      8'h88

// Field positions.
`define IDP_MODE_MULT_BIT   0
`define IDP_MODE_MDMA_LSB   4
`define IDP_MODE_UDMA_LSB   8
`define IDP_STRLEN_MOD_LSB  8

// Reset values of the changeable fields, then fixed page constants.
`define IDP_RST_MULT      1'b1
`define IDP_RST_MDMA      2'h3
`define IDP_RST_UDMA      3'h6
`define IDP_RST_SATA_EN   16'h0040
`define IDP_RST_FEAT85    16'h7429
`define IDP_RST_FEAT86    16'h3401
`define IDP_RST_FEAT87    16'h4020
`define IDP_RST_SECURITY  16'h0021
`define IDP_SATA_SUP      16'h0048
`define IDP_CHAR_SPACE    8'h20
`define IDP_SIGNATURE     8'ha5
`define IDP_LAST_WORD     8'hff

`endif

// File: verilog/idpage_pkg.sv
// Types shared by the identify page block.
package idpage_pkg;

  typedef enum logic [0:0] {
    IDP_IDLE = 1'b0,
    IDP_SEND = 1'b1
  } idpage_state_t;

endpackage

// File: verilog/idpage_top.sv
// Identify parameter page generator with APB configuration and PIO data-in word stream.
`timescale 1ns/100ps
`default_nettype none
`include "idpage_params.svh"

module idpage_top
  import idpage_pkg::*;
#(
  parameter int          APB_AW      = 8,
  parameter int          QUEUE_DEPTH = 32,
  parameter logic [15:0] MULT_MAX    = 16'h8001,
  parameter logic [15:0] ERASE_TIME  = 16'h0003,
  parameter logic [15:0] CYLINDERS   = 16'h3fff,
  parameter logic [15:0] HEADS       = 16'h0010,
  parameter logic [15:0] SECTORS     = 16'h003f
)
(
  // Clock and reset.
  input  wire logic              CLK_SYS,
  input  wire logic              RESET,
  // APB slave.
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [APB_AW-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Identify command from the command decoder.
  input  wire logic              IDENT_CMD,
  output logic                   BUSY,
  // PIO data-in word stream.
  output logic                   DIN_VALID,
  output logic      [15:0]       DIN_DATA,
  output logic                   DIN_LAST,
  input  wire logic              DIN_READY
);

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------

  // Picks the character at position sel of a packed word; position 0 is the first.
  function automatic logic [7:0] pick_char(input logic [31:0] w, input logic [1:0] sel);
    logic [7:0] c;
    c = w[8*sel +: 8];
    return c;
  endfunction

  // True when byte address a lies in the window of n bytes that starts at base.
  function automatic logic in_win(input logic [7:0] a, input logic [7:0] base,
                                  input logic [7:0] n);
    logic hit;
    hit = (a >= base) && (a < 8'(base + n));
    return hit;
  endfunction

  // Current capacity is the product of the default geometry.
  localparam logic [31:0] CUR_CAP = 32'(CYLINDERS) * 32'(HEADS) * 32'(SECTORS);
  localparam logic [15:0] QD_WORD = 16'(QUEUE_DEPTH - 1);

  //----------------------------------------------------------------------------
  // Configuration registers
  //----------------------------------------------------------------------------

  logic [31:0]   lba28_r;
  logic [31:0]   lba48_lo_r;
  logic [31:0]   lba48_hi_r;
  logic          mult_r;
  logic [1:0]    mdma_r;
  logic [2:0]    udma_r;
  logic [15:0]   sata_en_r;
  logic [15:0]   feat85_r;
  logic [15:0]   feat86_r;
  logic [15:0]   feat87_r;
  logic [15:0]   sec_r;
  logic [4:0]    ser_len_r;
  logic [5:0]    mod_len_r;
  // String memories are not reset; software fills them before the first page.
  logic [31:0]   ser_mem [0:4];
  logic [31:0]   mod_mem [0:9];
  logic [31:0]   fw_mem  [0:1];

  idpage_state_t state_r;
  logic [7:0]    idx_r;
  logic [7:0]    sum_r;
  logic [15:0]   data_r;

  //----------------------------------------------------------------------------
  // APB decode
  //----------------------------------------------------------------------------

  // Every access is answered at once, so PREADY is tied high. Only the low byte
  // selects a register; an address at or above 100h is refused as unmapped, but the
  // page start decodes the low byte alone, so such a write with low byte 00h and bit 0 set starts a page.
  wire         apb_acc   = PSEL && PENABLE;
  wire         apb_wr    = apb_acc && PWRITE;
  wire  [7:0]  a8        = 8'(PADDR);
  wire         hit_ser   = in_win(a8, `IDP_SERIAL_BASE, 8'h14);
  wire         hit_mod   = in_win(a8, `IDP_MODEL_BASE, 8'h28);
  wire         hit_fw    = in_win(a8, `IDP_FW_BASE, 8'h08);
  wire  [7:0]  ser_off   = a8 - `IDP_SERIAL_BASE;
  wire  [7:0]  mod_off   = a8 - `IDP_MODEL_BASE;
  wire  [7:0]  fw_off    = a8 - `IDP_FW_BASE;
  wire  [2:0]  ser_wi    = ser_off[4:2];
  wire  [3:0]  mod_wi    = mod_off[5:2];
  wire         fw_wi     = fw_off[2];
  wire         hit_regs  = (a8 <= `IDP_REG_STRLEN) && (a8[1:0] == 2'b00);
  wire         aligned   = (32'(PADDR) < 32'h0000_0100) && (a8[1:0] == 2'b00);
  wire         mapped    = aligned && (hit_regs || hit_ser || hit_mod || hit_fw);
  wire         ctrl_go   = apb_wr && (a8 == `IDP_REG_CTRL) && PWDATA[0];

  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc && !mapped;

  //----------------------------------------------------------------------------
  // Register writes
  //----------------------------------------------------------------------------

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      lba28_r    <= 32'h0000_0000;
      lba48_lo_r <= 32'h0000_0000;
      lba48_hi_r <= 32'h0000_0000;
      mult_r     <= `IDP_RST_MULT;
      mdma_r     <= `IDP_RST_MDMA;
      udma_r     <= `IDP_RST_UDMA;
      sata_en_r  <= `IDP_RST_SATA_EN;
      feat85_r   <= `IDP_RST_FEAT85;
      feat86_r   <= `IDP_RST_FEAT86;
      feat87_r   <= `IDP_RST_FEAT87;
      sec_r      <= `IDP_RST_SECURITY;
      ser_len_r  <= 5'h00;
      mod_len_r  <= 6'h00;
    end
    // Refused accesses change no register. An ultra mode of 7 is dropped so that the
    // mode selected in word 88 stays within the supported modes 0 to 6.
    else if (apb_wr && mapped)
    begin
      unique case (a8)
        `IDP_REG_LBA28:    lba28_r <= PWDATA;
        `IDP_REG_LBA48_LO: lba48_lo_r <= PWDATA;
        `IDP_REG_LBA48_HI: lba48_hi_r <= PWDATA;
        `IDP_REG_MODE:
        begin
          mult_r <= PWDATA[`IDP_MODE_MULT_BIT];
          mdma_r <= PWDATA[`IDP_MODE_MDMA_LSB +: 2];
          udma_r <= (PWDATA[`IDP_MODE_UDMA_LSB +: 3] == 3'h7) ? udma_r
                    : PWDATA[`IDP_MODE_UDMA_LSB +: 3];
        end
        `IDP_REG_SATA_EN:  sata_en_r <= PWDATA[15:0] & `IDP_SATA_SUP;
        `IDP_REG_FEAT85:   feat85_r <= PWDATA[15:0];
        `IDP_REG_FEAT86:   feat86_r <= PWDATA[15:0];
        `IDP_REG_FEAT87:   feat87_r <= PWDATA[15:0];
        `IDP_REG_SECURITY: sec_r <= PWDATA[15:0];
        `IDP_REG_STRLEN:
        begin
          ser_len_r <= (PWDATA[4:0] > 5'd20) ? 5'd20 : PWDATA[4:0];
          mod_len_r <= (PWDATA[`IDP_STRLEN_MOD_LSB +: 6] > 6'd40) ? 6'd40
                       : PWDATA[`IDP_STRLEN_MOD_LSB +: 6];
        end
        default: ;
      endcase
    end
  end

  // String memories hold characters only; padding is applied when the page is built.
  always_ff @(posedge CLK_SYS)
  begin
    if (apb_wr && aligned && hit_ser)
      ser_mem[ser_wi] <= PWDATA;
    if (apb_wr && aligned && hit_mod)
      mod_mem[mod_wi] <= PWDATA;
    if (apb_wr && aligned && hit_fw)
      fw_mem[fw_wi] <= PWDATA;
  end

  //----------------------------------------------------------------------------
  // APB read
  //----------------------------------------------------------------------------

  // Read data is zero outside a mapped read access, so no stale word leaks onto
  // the bus during setup or idle cycles.
  wire [31:0] mode_rd = {21'h0, udma_r, 2'b00, mdma_r, 3'b000, mult_r};
  wire [31:0] stat_rd = {16'h0, idx_r, 7'h0, BUSY};
  wire [31:0] len_rd  = {18'h0, mod_len_r, 3'b000, ser_len_r};
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ser)
      rd_mux = ser_mem[ser_wi];
    else if (hit_mod)
      rd_mux = mod_mem[mod_wi];
    else if (hit_fw)
      rd_mux = fw_mem[fw_wi];
    else
    begin
      unique case (a8)
        `IDP_REG_CTRL:     rd_mux = stat_rd;
        `IDP_REG_LBA28:    rd_mux = lba28_r;
        `IDP_REG_LBA48_LO: rd_mux = lba48_lo_r;
        `IDP_REG_LBA48_HI: rd_mux = lba48_hi_r;
        `IDP_REG_MODE:     rd_mux = mode_rd;
        `IDP_REG_SATA_EN:  rd_mux = {16'h0, sata_en_r};
        `IDP_REG_FEAT85:   rd_mux = {16'h0, feat85_r};
        `IDP_REG_FEAT86:   rd_mux = {16'h0, feat86_r};
        `IDP_REG_FEAT87:   rd_mux = {16'h0, feat87_r};
        `IDP_REG_SECURITY: rd_mux = {16'h0, sec_r};
        `IDP_REG_STRLEN:   rd_mux = len_rd;
        default:           rd_mux = 32'h0000_0000;
      endcase
    end
  end

  assign PRDATA = (apb_acc && !PWRITE && mapped) ? rd_mux : 32'h0000_0000;

  //----------------------------------------------------------------------------
  // Page word builder
  //----------------------------------------------------------------------------

  // The builder works one word ahead: page_w is the word after the one on offer,
  // so it is latched into data_r at the edge at which the host takes the current
  // word. Configuration changed during a transfer only affects words not yet
  // latched.
  wire         send      = (state_r == IDP_SEND);
  wire         take      = send && DIN_READY;
  wire         start     = !send && (IDENT_CMD || ctrl_go);
  wire  [7:0]  rd_idx    = send ? idx_r + 8'h01 : 8'h00;
  wire  [7:0]  sum_nxt   = send ? sum_r + data_r[15:8] + data_r[7:0] : 8'h00;
  wire  [7:0]  chk_byte  = 8'h00 - sum_nxt - `IDP_SIGNATURE;
  wire  [7:0]  mdma_sel  = (mdma_r == 2'h3) ? 8'h00 : 8'(8'h01 << mdma_r);
  wire  [7:0]  udma_sel  = 8'(8'h01 << udma_r);
  wire  [4:0]  ser_pad   = 5'd20 - ser_len_r;
  logic [15:0] page_w;

  always_comb
  begin
    logic [7:0] pos;
    logic [7:0] q;
    logic [7:0] ch [0:1];
    pos    = 8'h00;
    q      = 8'h00;
    ch[0]  = `IDP_CHAR_SPACE;
    ch[1]  = `IDP_CHAR_SPACE;
    page_w = 16'h0000;
    // Serial characters are right-justified: the leading positions are spaces.
    if (rd_idx >= 8'd10 && rd_idx <= 8'd19)
    begin
      for (int k = 0; k < 2; k++)
      begin
        pos = 8'((rd_idx - 8'd10) << 1) + 8'(k);
        q   = pos - 8'(ser_pad);
        ch[k] = (pos < 8'(ser_pad)) ? `IDP_CHAR_SPACE
                : pick_char(ser_mem[q[4:2]], q[1:0]);
      end
      page_w = {ch[0], ch[1]};
    end
    else if (rd_idx >= 8'd23 && rd_idx <= 8'd26)
    begin
      pos    = 8'((rd_idx - 8'd23) << 1);
      page_w = {pick_char(fw_mem[pos[2]], pos[1:0]),
                pick_char(fw_mem[pos[2]], pos[1:0] + 2'd1)};
    end
    else if (rd_idx >= 8'd27 && rd_idx <= 8'd46)
    begin
      for (int k = 0; k < 2; k++)
      begin
        pos   = 8'((rd_idx - 8'd27) << 1) + 8'(k);
        ch[k] = (pos >= 8'(mod_len_r)) ? `IDP_CHAR_SPACE
                : pick_char(mod_mem[pos[5:2]], pos[1:0]);
      end
      page_w = {ch[0], ch[1]};
    end
    else
    begin
      case (rd_idx)
        8'd0:   page_w = 16'h0040;
        8'd1:   page_w = CYLINDERS;
        8'd2:   page_w = 16'hc837;
        8'd3:   page_w = HEADS;
        8'd5:   page_w = 16'h0240;
        8'd6:   page_w = SECTORS;
        8'd22:  page_w = 16'h0004;
        8'd47:  page_w = MULT_MAX;
        8'd49:  page_w = 16'h0f00;
        8'd50:  page_w = 16'h4000;
        8'd51:  page_w = 16'h0200;
        8'd53:  page_w = 16'h0007;
        8'd54:  page_w = CYLINDERS;
        8'd55:  page_w = HEADS;
        8'd56:  page_w = SECTORS;
        8'd57:  page_w = CUR_CAP[15:0];
        8'd58:  page_w = CUR_CAP[31:16];
        8'd59:  page_w = {7'h00, 1'b1, 7'h00, mult_r};
        8'd60:  page_w = lba28_r[15:0];
        8'd61:  page_w = lba28_r[31:16];
        8'd63:  page_w = {mdma_sel, 8'h07};
        8'd64:  page_w = 16'h0003;
        8'd65,
        8'd66,
        8'd67,
        8'd68:  page_w = 16'h0078;
        8'd75:  page_w = QD_WORD;
        8'd76:  page_w = 16'h0306;
        8'd78:  page_w = `IDP_SATA_SUP;
        8'd79:  page_w = sata_en_r;
        8'd80:  page_w = 16'h03f0;
        8'd82:  page_w = 16'h742b;
        8'd83:  page_w = 16'h7501;
        8'd84:  page_w = 16'h4020;
        8'd85:  page_w = feat85_r;
        8'd86:  page_w = feat86_r;
        8'd87:  page_w = feat87_r;
        8'd88:  page_w = {udma_sel, 8'h7f};
        8'd89:  page_w = ERASE_TIME;
        8'd92:  page_w = 16'hfffe;
        8'd100: page_w = lba48_lo_r[15:0];
        8'd101: page_w = lba48_lo_r[31:16];
        8'd102: page_w = lba48_hi_r[15:0];
        8'd103: page_w = lba48_hi_r[31:16];
        8'd105: page_w = 16'h0100;
        8'd128: page_w = sec_r;
        8'd209: page_w = 16'h4000;
        8'd217: page_w = 16'h0001;
        8'd255: page_w = {chk_byte, `IDP_SIGNATURE};
        default: page_w = 16'h0000;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // PIO data-in sequencer
  //----------------------------------------------------------------------------

  // The checksum runs over the words as they leave, so word 255 always matches
  // the 255 words that the host actually received.
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      state_r <= IDP_IDLE;
      idx_r   <= 8'h00;
      sum_r   <= 8'h00;
      data_r  <= 16'h0000;
    end
    else if (start || (take && idx_r != `IDP_LAST_WORD))
    begin
      state_r <= IDP_SEND;
      idx_r   <= rd_idx;
      sum_r   <= sum_nxt;
      data_r  <= page_w;
    end
    else if (take)
    begin
      state_r <= IDP_IDLE;
      idx_r   <= 8'h00;
    end
  end

  // Valid and busy come straight from the state register, so the word on offer
  // never depends on the host's ready in the same cycle.
  assign BUSY      = send;
  assign DIN_VALID = send;
  assign DIN_DATA  = data_r;
  assign DIN_LAST  = send && (idx_r == `IDP_LAST_WORD);

endmodule

`default_nettype wire

// File: verif/idpage_assertions.sv
// Concurrent checks on the identify page word stream.
`timescale 1ns/100ps
`default_nettype none
module idpage_assertions
#(
  parameter int QUEUE_DEPTH = 32
)
(
  // Clock and reset.
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // Page stream.
  input wire logic        IDENT_CMD,
  input wire logic        BUSY,
  input wire logic        DIN_VALID,
  input wire logic [15:0] DIN_DATA,
  input wire logic        DIN_LAST,
  input wire logic        DIN_READY
);
  logic [7:0] idx_r;
  logic [7:0] sum_r;

  // Index of the word on offer and byte sum of the words already taken.
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET || !DIN_VALID)
    begin
      idx_r <= 8'h00;
      sum_r <= 8'h00;
    end
    else if (DIN_READY)
    begin
      idx_r <= idx_r + 8'h01;
      sum_r <= sum_r + DIN_DATA[15:8] + DIN_DATA[7:0];
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence s_start; IDENT_CMD && !BUSY; endsequence
  sequence s_take; DIN_VALID && DIN_READY; endsequence
  sequence s_stall; DIN_VALID && !DIN_READY; endsequence

  a_start_word: assert property (s_start |=> DIN_VALID && DIN_DATA == 16'h0040)
    else $error("first page word wrong");
  a_hold_word: assert property (s_stall |=> DIN_VALID && $stable(DIN_DATA))
    else $error("word changed before it was taken");
  a_end_stream: assert property (s_take ##0 DIN_LAST |=> !BUSY && !DIN_VALID)
    else $error("stream did not stop after last word");
  a_last_index: assert property (DIN_VALID |-> DIN_LAST == (idx_r == 8'hff))
    else $error("last flag not on word 255");
  a_sig_sum: assert property (DIN_VALID && DIN_LAST |-> DIN_DATA[7:0] == 8'ha5
    && 8'(sum_r + DIN_DATA[15:8] + DIN_DATA[7:0]) == 8'h00) else $error("integrity word wrong");
  a_word_two: assert property (DIN_VALID && idx_r == 8'd2 |-> DIN_DATA == 16'hc837)
    else $error("word 2 wrong");
  a_caps_word: assert property (DIN_VALID && idx_r == 8'd49 |-> DIN_DATA == 16'h0f00)
    else $error("word 49 wrong");
  a_pio_word: assert property (DIN_VALID && idx_r == 8'd51 |-> DIN_DATA == 16'h0200)
    else $error("word 51 wrong");
  a_valid_word: assert property (DIN_VALID && idx_r == 8'd53 |-> DIN_DATA == 16'h0007)
    else $error("word 53 wrong");
  a_mult_word: assert property (DIN_VALID && idx_r == 8'd59 |-> DIN_DATA[15:1] == 15'h0080)
    else $error("word 59 wrong");
  a_cycle_words: assert property (DIN_VALID && idx_r inside {[65:68]} |-> DIN_DATA == 16'h0078)
    else $error("cycle time word wrong");
  a_queue_word: assert property (DIN_VALID && idx_r == 8'd75 |-> DIN_DATA == 16'(QUEUE_DEPTH - 1))
    else $error("word 75 wrong");
  a_rotation_word: assert property (DIN_VALID && idx_r == 8'd217 |-> DIN_DATA == 16'h0001)
    else $error("word 217 wrong");
endmodule

bind idpage_top idpage_assertions #(.QUEUE_DEPTH(QUEUE_DEPTH)) i_chk (.CLK_SYS(CLK_SYS),
  .RESET(RESET), .IDENT_CMD(IDENT_CMD), .BUSY(BUSY), .DIN_VALID(DIN_VALID),
  .DIN_DATA(DIN_DATA), .DIN_LAST(DIN_LAST), .DIN_READY(DIN_READY));
`default_nettype wire

// File: verif/idpage_host_model.sv
// Host model that reads the identify page from the data-in word stream.
`timescale 1ns/100ps
`default_nettype none
module idpage_host_model
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Stream from the drive.
  input  wire logic        valid,
  input  wire logic [15:0] data,
  input  wire logic        last,
  output logic             ready,
  // Control and results.
  input  wire logic        stall,
  output logic [15:0]      page [256],
  output var int           words,
  output var int           pages
);
  logic [7:0]  idx_r;
  logic [15:0] lfsr_r;

  // A stalling host drops ready at pseudo-random cycles.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ready  <= 1'b0;
      idx_r  <= 8'h00;
      lfsr_r <= 16'hace1;
      words  <= 0;
      pages  <= 0;
    end
    else
    begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      ready  <= stall ? lfsr_r[0] : 1'b1;
      if (valid && ready)
      begin
        page[idx_r] <= data;
        idx_r       <= last ? 8'h00 : idx_r + 8'h01;
        words       <= words + 1;
        pages       <= pages + (last ? 1 : 0);
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/identify_parameter_page_tb.sv
// Self-checking testbench of the identify page block.
`timescale 1ns/100ps
`default_nettype none
module identify_parameter_page_tb;
  localparam logic [7:0]  RA [8] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
  localparam logic [31:0] RV [8] = '{0, 32'h631, 32'h40, 32'h7429, 32'h3401, 32'h4020, 32'h21, 0};
  logic        CLK_SYS, RESET, PSEL, PENABLE, PWRITE, IDENT_CMD, STALL, mult, er;
  logic        PREADY, PSLVERR, BUSY, DIN_VALID, DIN_LAST, DIN_READY;
  logic [7:0]  PADDR, slen, mlen, sum;
  logic [31:0] PWDATA, PRDATA, rd, wd, seed, lba28;
  logic [63:0] lba48;
  logic [15:0] DIN_DATA, sata, f85, sec;
  logic [15:0] page [256];
  logic [7:0]  mem [256];
  logic [1:0]  mdma;
  logic [2:0]  udma;
  int          words, pages, error_cnt, total_checks;

  idpage_top i_dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IDENT_CMD(IDENT_CMD), .BUSY(BUSY), .DIN_VALID(DIN_VALID),
    .DIN_DATA(DIN_DATA), .DIN_LAST(DIN_LAST), .DIN_READY(DIN_READY));
  idpage_host_model i_host (.clk(CLK_SYS), .rst(RESET), .valid(DIN_VALID), .data(DIN_DATA),
    .last(DIN_LAST), .ready(DIN_READY), .stall(STALL), .page(page), .words(words),
    .pages(pages));

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  function automatic logic [31:0] xrnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] sch(int p);
    return (p < 20 - slen) ? 8'h20 : mem[44 + p + slen];
  endfunction

  function automatic logic [7:0] mch(int p);
    return (p < mlen) ? mem[96 + p] : 8'h20;
  endfunction

  function automatic logic [16:0] expw(int w);
    logic [15:0] v;
    if (w >= 10 && w <= 19) return {1'b1, sch(2 * w - 20), sch(2 * w - 19)};
    if (w >= 27 && w <= 46) return {1'b1, mch(2 * w - 54), mch(2 * w - 53)};
    if (w >= 23 && w <= 26) return {1'b1, mem[90 + 2 * w], mem[91 + 2 * w]};
    if (w inside {4, [7:9], 20, 21, 48, 52, 62, [69:74], 77, 81, [90:91], [93:99], 104,
                  [106:127], [160:208], [210:216], [218:254]}) return 17'h10000;
    case (w)
      0: v = 16'h0040;
      2: v = 16'hc837;
      47: v = 16'h8001;
      49: v = 16'h0f00;
      51: v = 16'h0200;
      53: v = 16'h0007;
      59: v = {15'h0080, mult};
      60: v = lba28[15:0];
      61: v = lba28[31:16];
      63: v = 16'h0007 | ((mdma == 2'h3) ? 16'h0 : 16'h0100 << mdma);
      64: v = 16'h0003;
      65, 66, 67, 68: v = 16'h0078;
      75: v = 16'h001f;
      76: v = 16'h0306;
      78: v = 16'h0048;
      79: v = sata & 16'h0048;
      85: v = f85;
      86: v = 16'h3401;
      87: v = 16'h4020;
      88: v = 16'h007f | (16'h0100 << udma);
      89: v = 16'h0003;
      100, 101, 102, 103: v = lba48[16 * (w - 100) +: 16];
      128: v = sec;
      209: v = 16'h4000;
      217: v = 16'h0001;
      default: return 17'h0;
    endcase
    return {1'b1, v};
  endfunction

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (PREADY !== 1'b1 && n < 64);
    rd = PRDATA;
    er = PSLVERR;
    chk("apb answer", 1, PREADY);
    if (PREADY !== 1'b1) give_verdict();
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask

  task set_cfg();
    apb(1'b1, 8'h10, {21'h0, udma, 2'h0, mdma, 3'h0, mult});
    apb(1'b1, 8'h14, {16'h0, sata});
    apb(1'b1, 8'h18, {16'h0, f85});
    apb(1'b1, 8'h24, {16'h0, sec});
    apb(1'b1, 8'h28, {18'h0, mlen[5:0], 3'h0, slen[4:0]});
  endtask

  task run_page(input logic by_reg);
    int n, p0, w0;
    p0 = pages;
    w0 = words;
    if (by_reg) apb(1'b1, 8'h00, 32'h1);
    else
    begin
      IDENT_CMD <= 1'b1;
      @(posedge CLK_SYS);
      IDENT_CMD <= 1'b0;
    end
    repeat (3) @(posedge CLK_SYS);
    IDENT_CMD <= 1'b1;
    @(posedge CLK_SYS);
    IDENT_CMD <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("busy bit", 1, rd[0]);
    for (n = 0; n < 4000 && pages == p0; n++) @(posedge CLK_SYS);
    chk("page done", 1, pages != p0);
    if (pages == p0) give_verdict();
    chk("page length", 256, words - w0);
    sum = 8'h00;
    for (int w = 0; w < 256; w++)
    begin
      sum = sum + page[w][15:8] + page[w][7:0];
      if (expw(w) >> 16) chk($sformatf("word %0d", w), expw(w) & 17'hffff, page[w]);
    end
    chk("page sum", 0, sum);
    chk("signature", 8'ha5, page[255][7:0]);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  initial
  begin
    {RESET, PSEL, PENABLE, PWRITE, IDENT_CMD, STALL} = 6'h20;
    PADDR = 8'h0;
    PWDATA = 32'h0;
    {seed, error_cnt, total_checks} = {32'd26, 64'h0};
    {mult, mdma, udma, slen, mlen} = {1'b1, 2'h3, 3'h6, 16'h0};
    {sata, f85, sec} = {16'h0040, 16'h7429, 16'h0021};
    repeat (6) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, RA[i], 32'h0);
      chk("reset value", RV[i], rd);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped data", 0, rd);
    chk("unmapped error", 1, er);
    apb(1'b1, 8'h12, 32'h0);
    chk("unaligned error", 1, er);
    for (int a = 8'h40; a < 8'h90; a += 4)
    begin
      wd = xrnd();
      {mem[a + 3], mem[a + 2], mem[a + 1], mem[a]} = wd;
      apb(1'b1, a[7:0], wd);
    end
    lba28 = xrnd() & 32'h0fffffff;
    lba48 = {16'h0, 16'(xrnd()), xrnd()};
    apb(1'b1, 8'h04, lba28);
    apb(1'b1, 8'h08, lba48[31:0]);
    apb(1'b1, 8'h0c, lba48[63:32]);
    run_page(1'b0);
    for (int i = 0; i < 7; i++)
    begin
      wd = xrnd();
      {mult, mdma, udma} = {wd[0], 2'(i % 4), 3'(i)};
      STALL <= wd[31];
      {slen, mlen, sata, f85, sec} = {8'(wd[20:16] % 21), 8'(wd[29:24] % 41), xrnd(), 16'h0};
      {f85, sec} = xrnd();
      set_cfg();
      run_page(wd[1]);
    end
    {slen, mlen} = {8'd20, 8'd40};
    STALL <= 1'b1;
    set_cfg();
    apb(1'b1, 8'h10, {21'h0, 3'h7, 2'h0, mdma, 3'h0, mult});
    run_page(1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
